// File: shared/irq_ctrl_pkg.sv
// Package: register map, field layout and constants of the interrupt block
package irq_ctrl_pkg;
  localparam int NUM_IRQ = 32;
  localparam int ADDR_W = 12;
  // Byte addresses on the register bus
  localparam logic [11:0] OFF_ENABLE_SET = 12'h100;
  localparam logic [11:0] OFF_ENABLE_CLEAR = 12'h180;
  localparam logic [11:0] OFF_PENDING_SET = 12'h200;
  localparam logic [11:0] OFF_PENDING_CLEAR = 12'h280;
  localparam logic [11:0] OFF_PRIO_BASE = 12'h400;
  localparam logic [11:0] OFF_PRIO_LAST = 12'h41C;
  localparam logic [11:0] OFF_ACTIVE = 12'h300;
  localparam logic [11:0] OFF_LEVEL_MODE = 12'h304;
  localparam logic [11:0] OFF_DELIVERY = 12'h308;
  localparam int PRIO_W = 2;
  localparam int PRIO_LANE_W = 8;
  localparam int PRIO_MSB = 7;
  localparam int PRIO_LSB = 6;
  localparam int PRIO_PER_WORD = 4;
  localparam int PRIO_WORDS = 8;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_WORD = 32'h0000_0000;
  localparam logic [1:0] PRIO_LOWEST = 2'h3;
  localparam logic [3:0] BE_FULL = 4'hF;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_t;
endpackage

// File: logic/irq_pending_priority_ctrl.sv
// Interrupt pending, active and priority tracking with Avalon-MM registers
`timescale 1ns/1ps
module irq_pending_priority_ctrl #(
  parameter int NUM_IRQ = irq_ctrl_pkg::NUM_IRQ
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NUM_IRQ-1:0] irq_lines,
  input wire logic handler_enter,
  input wire logic [4:0] handler_enter_num,
  input wire logic handler_exit,
  input wire logic [4:0] handler_exit_num,
  output logic irq_offer_valid,
  output logic [4:0] irq_offer_num,
  output logic [1:0] irq_offer_prio
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers

  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  logic [NUM_IRQ-1:0] line_meta_q;
  logic [NUM_IRQ-1:0] line_q;
  logic [NUM_IRQ-1:0] line_prev_q;
  // Line sampled each rising edge; edge seen after two-stage sync
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      line_meta_q <= '0;
      line_q <= '0;
      line_prev_q <= '0;
    end else begin
      line_meta_q <= irq_lines;
      line_q <= line_meta_q;
      line_prev_q <= line_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  irq_ctrl_pkg::bus_state_t bus_q;
  logic wr_ok;
  logic hit_active;
  logic hit_delivery;
  logic [31:0] wdata;
  logic hit_en_set;
  logic hit_en_clr;
  logic hit_pd_set;
  logic hit_pd_clr;
  logic hit_prio;
  logic hit_level;
  logic [2:0] prio_idx;

  // Exact word match; partial offsets fall through to the unmapped word
  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] off);
    return a == off;
  endfunction

  // One-cycle wait: requests are taken in idle, answered a cycle later
  // Writes land on the answer edge, while the master still holds them
  assign wr_ok = avs_write && (bus_q == irq_ctrl_pkg::BUS_DONE);
  assign wdata = avs_writedata;
  assign hit_en_set = addr_is(avs_address, irq_ctrl_pkg::OFF_ENABLE_SET);
  assign hit_en_clr = addr_is(avs_address, irq_ctrl_pkg::OFF_ENABLE_CLEAR);
  assign hit_pd_set = addr_is(avs_address, irq_ctrl_pkg::OFF_PENDING_SET);
  assign hit_pd_clr = addr_is(avs_address, irq_ctrl_pkg::OFF_PENDING_CLEAR);
  assign hit_level = addr_is(avs_address, irq_ctrl_pkg::OFF_LEVEL_MODE);
  assign hit_active = addr_is(avs_address, irq_ctrl_pkg::OFF_ACTIVE);
  assign hit_delivery = addr_is(avs_address, irq_ctrl_pkg::OFF_DELIVERY);
  // Misaligned addresses simply miss the decode
  assign hit_prio = (avs_address >= irq_ctrl_pkg::OFF_PRIO_BASE) &&
                    (avs_address <= irq_ctrl_pkg::OFF_PRIO_LAST) &&
                    (avs_address[1:0] == 2'h0);
  assign prio_idx = avs_address[4:2];

  ////////////////////////////////////////////////////////////////////////
  // Enable bank and level/pulse mode

  logic [NUM_IRQ-1:0] enable_q;
  logic [NUM_IRQ-1:0] level_mode_q;
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      enable_q <= '0;
    end else if (wr_ok && hit_en_set) begin
      enable_q <= enable_q | wdata[NUM_IRQ-1:0];
    end else if (wr_ok && hit_en_clr) begin
      enable_q <= enable_q & ~wdata[NUM_IRQ-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      level_mode_q <= '0;
    end else if (wr_ok && hit_level) begin
      level_mode_q <= wdata[NUM_IRQ-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Priority words

  logic [irq_ctrl_pkg::PRIO_W-1:0] prio_q [NUM_IRQ];

  // Bit position within the word of the stored field of a lane
  function automatic int lane_lsb(input int lane);
    return lane * irq_ctrl_pkg::PRIO_LANE_W + irq_ctrl_pkg::PRIO_LSB;
  endfunction

  // Partial writes dropped: the words are full-word only
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        prio_q[i] <= '0;
      end
    end else if (wr_ok && hit_prio &&
                 avs_byteenable == irq_ctrl_pkg::BE_FULL) begin
      for (int l = 0; l < irq_ctrl_pkg::PRIO_PER_WORD; l++) begin
        prio_q[prio_idx*irq_ctrl_pkg::PRIO_PER_WORD + l] <=
          wdata[lane_lsb(l) +: irq_ctrl_pkg::PRIO_W];
      end
    end
  end

  function automatic logic [31:0] prio_word(input logic [2:0] idx);
    logic [31:0] w;
    w = '0;
    for (int l = 0; l < irq_ctrl_pkg::PRIO_PER_WORD; l++) begin
      w[lane_lsb(l) +: irq_ctrl_pkg::PRIO_W] =
        prio_q[idx*irq_ctrl_pkg::PRIO_PER_WORD + l];
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pending and active state

  logic [NUM_IRQ-1:0] pending_q;
  logic [NUM_IRQ-1:0] active_q;
  logic [NUM_IRQ-1:0] pend_d;
  logic [NUM_IRQ-1:0] act_d;
  logic [NUM_IRQ-1:0] sw_set;
  logic [NUM_IRQ-1:0] sw_clr;
  logic [NUM_IRQ-1:0] enter_vec;
  logic [NUM_IRQ-1:0] exit_vec;

  assign sw_set = (wr_ok && hit_pd_set) ? wdata[NUM_IRQ-1:0] : '0;
  assign sw_clr = (wr_ok && hit_pd_clr) ? wdata[NUM_IRQ-1:0] : '0;
  // One bit per line number from the core
  function automatic logic [NUM_IRQ-1:0] one_line(input logic [4:0] num);
    return NUM_IRQ'(1) << num;
  endfunction

  assign enter_vec = handler_enter ? one_line(handler_enter_num) : '0;
  assign exit_vec = handler_exit ? one_line(handler_exit_num) : '0;

  always_comb begin
    for (int i = 0; i < NUM_IRQ; i++) begin
      pend_d[i] = pending_q[i];
      act_d[i] = active_q[i];
      if (sw_clr[i]) begin
        // Level line still high keeps its state, even while active
        if (level_mode_q[i]) begin
          pend_d[i] = pending_q[i] && line_q[i];
        end else begin
          pend_d[i] = 1'b0;
        end
      end
      if (enter_vec[i] && pending_q[i]) begin
        pend_d[i] = 1'b0;
        act_d[i] = 1'b1;
      end
      if (exit_vec[i]) begin
        act_d[i] = 1'b0;
        if (level_mode_q[i]) begin
          pend_d[i] = pend_d[i] || line_q[i];
        end
      end
      // Edge and software sets win over any clear; a level set only applies while the line is not active
      if (level_mode_q[i] && line_q[i] && !act_d[i]) begin
        pend_d[i] = 1'b1;
      end
      if (!level_mode_q[i] && line_q[i] && !line_prev_q[i]) begin
        pend_d[i] = 1'b1;
      end
      if (sw_set[i]) begin
        pend_d[i] = 1'b1;
      end
    end
  end

  // Pending and active kept in separate registers, one concern each
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pending_q <= '0;
    end else begin
      pending_q <= pend_d;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      active_q <= '0;
    end else begin
      active_q <= act_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Delivery selection

  logic sel_valid;
  logic [4:0] sel_num;
  logic [1:0] sel_prio;
  always_comb begin
    sel_valid = 1'b0;
    sel_num = '0;
    sel_prio = irq_ctrl_pkg::PRIO_LOWEST;
    // Strict less-than keeps the lowest number on a tie
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (pending_q[i] && enable_q[i] &&
          (!sel_valid || prio_q[i] < sel_prio)) begin
        sel_valid = 1'b1;
        sel_num = 5'(i);
        sel_prio = prio_q[i];
      end
    end
  end

  // Registered offer: the core sees state one cycle late
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      irq_offer_valid <= 1'b0;
      irq_offer_num <= '0;
      irq_offer_prio <= '0;
    end else begin
      irq_offer_valid <= sel_valid;
      irq_offer_num <= sel_num;
      irq_offer_prio <= sel_prio;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus answer

  // Delivery status word: number, urgency and a valid flag
  function automatic logic [31:0] status_word(input logic valid,
                                              input logic [1:0] prio,
                                              input logic [4:0] num);
    logic [31:0] w;
    w = irq_ctrl_pkg::UNMAPPED_WORD;
    w[4:0] = num;
    w[6:5] = prio;
    w[8] = valid;
    return w;
  endfunction

  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = irq_ctrl_pkg::UNMAPPED_WORD;
    if (hit_en_set || hit_en_clr) begin
      rdata_d[NUM_IRQ-1:0] = enable_q;
    end else if (hit_pd_set || hit_pd_clr) begin
      rdata_d[NUM_IRQ-1:0] = pending_q;
    end else if (hit_prio) begin
      rdata_d = prio_word(prio_idx);
    end else if (hit_active) begin
      rdata_d[NUM_IRQ-1:0] = active_q;
    end else if (hit_level) begin
      rdata_d[NUM_IRQ-1:0] = level_mode_q;
    end else if (hit_delivery) begin
      // Live selection, captured on the same edge as the offer pins, so a read matches them
      rdata_d = status_word(sel_valid, sel_prio, sel_num);
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      bus_q <= irq_ctrl_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= irq_ctrl_pkg::RESET_WORD;
    end else begin
      unique case (bus_q)
        irq_ctrl_pkg::BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q <= irq_ctrl_pkg::BUS_DONE;
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rdata_d : irq_ctrl_pkg::RESET_WORD;
          end
        end
        irq_ctrl_pkg::BUS_DONE: begin
          bus_q <= irq_ctrl_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_q <= irq_ctrl_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

endmodule // irq_pending_priority_ctrl

// File: tb/irq_ctrl_checker.sv
// Port-level assertions for the interrupt pending and priority block
`timescale 1ns/1ps
module irq_ctrl_checker #(
  parameter int NUM_IRQ = 32
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [NUM_IRQ-1:0] irq_lines,
  input wire logic handler_enter,
  input wire logic [4:0] handler_enter_num,
  input wire logic irq_offer_valid,
  input wire logic [4:0] irq_offer_num
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("no answer");
  property p_answer_once;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_answer_once: assert property (p_answer_once) else $error("long ans");
  property p_no_req;
    !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_no_req: assert property (p_no_req) else $error("stray answer");
  property p_low_bits;
    !avs_waitrequest && $past(avs_read) && $past(avs_address[11:5]) == 7'h20
      |-> (avs_readdata & 32'h3F3F_3F3F) == 32'h0000_0000;
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("low bits set");
  property p_unmapped;
    !avs_waitrequest && $past(avs_read) && $past(avs_address) == 12'h000
      |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  // Taken line must leave the offer; catches a missed pending-to-active move
  property p_enter;
    handler_enter && irq_offer_valid && irq_offer_num == handler_enter_num
      |-> ##3 !(irq_offer_valid && irq_offer_num == $past(handler_enter_num, 3));
  endproperty
  a_enter: assert property (p_enter) else $error("still offered");
  property p_rst_quiet;
    $rose(rst_n) |-> !irq_offer_valid [*3];
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("offer at reset");
  property p_clr_all;
    avs_write && avs_waitrequest && avs_address == 12'h280
      && avs_writedata == 32'hFFFF_FFFF && irq_lines == '0
      |-> ##3 !irq_offer_valid;
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("offer kept");
endmodule // irq_ctrl_checker

bind irq_pending_priority_ctrl irq_ctrl_checker #(.NUM_IRQ(NUM_IRQ)) u_chk (
  .mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .irq_lines, .handler_enter,
  .handler_enter_num, .irq_offer_valid, .irq_offer_num);

// File: tb/core_model.sv
// Processor core model: takes the offered interrupt, later returns from it
`timescale 1ns/1ps
module core_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic irq_offer_valid,
  input wire logic [4:0] irq_offer_num,
  input wire logic take,
  input wire logic leave,
  output logic handler_enter,
  output logic [4:0] handler_enter_num,
  output logic handler_exit,
  output logic [4:0] handler_exit_num
);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      handler_enter <= 1'b0;
      handler_enter_num <= 5'h00;
      handler_exit <= 1'b0;
      handler_exit_num <= 5'h00;
    end else begin
      // Only an offered line is ever taken
      handler_enter <= take && irq_offer_valid;
      handler_enter_num <= irq_offer_num;
      handler_exit <= leave;
      if (handler_enter) begin
        handler_exit_num <= handler_enter_num;
      end
    end
  end
endmodule // core_model

// File: tb/interrupt_pending_priority_ctrl_test.sv
// Self-checking bench for the interrupt pending and priority block
`timescale 1ns/1ps
module interrupt_pending_priority_ctrl_test;
  logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, take, leave;
  logic handler_enter, handler_exit, irq_offer_valid;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, irq_lines, q, r, pend_m, act_m;
  logic [3:0] avs_byteenable;
  logic [4:0] irq_offer_num, handler_enter_num, handler_exit_num;
  logic [1:0] irq_offer_prio;
  logic [1:0] pr_m [32];
  int failures, samples_checked, b;
  irq_pending_priority_ctrl dut (.mclk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .irq_lines, .handler_enter, .handler_enter_num,
    .handler_exit, .handler_exit_num, .irq_offer_valid, .irq_offer_num,
    .irq_offer_prio);
  core_model core (.mclk, .rst_n, .irq_offer_valid, .irq_offer_num, .take,
    .leave, .handler_enter, .handler_enter_num, .handler_exit,
    .handler_exit_num);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 40) begin
      failures++;
      conclude();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(q, exp);
  endtask
  // Lowest value wins; strict compare keeps the lowest number on ties
  function automatic logic [31:0] best(input logic [31:0] p);
    b = -1;
    for (int i = 0; i < 32; i++) begin
      if (p[i] && (b < 0 || pr_m[i] < pr_m[b])) begin
        b = i;
      end
    end
    return b < 0 ? 32'h0 : {23'h0, 1'b1, 1'b0, pr_m[b], 5'(b)};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n <= 1'b0;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= 12'h000;
    avs_writedata <= 32'h0000_0000;
    avs_byteenable <= 4'hF;
    irq_lines <= 32'h0000_0000;
    take <= 1'b0;
    leave <= 1'b0;
    void'($urandom(38));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(12'h200, 32'h0000_0000);
    rd(12'h404, 32'h0000_0000);
    rd(12'h000, 32'h0000_0000);
    $display("test 1 end");
    pend_m = $urandom() | 32'h1;
    bus(1'b1, 12'h200, pend_m, 4'hF);
    bus(1'b1, 12'h200, pend_m, 4'hF);
    r = $urandom() & 32'hFFFF_FFFE;
    pend_m = pend_m & ~r;
    bus(1'b1, 12'h280, r, 4'hF);
    rd(12'h200, pend_m);
    rd(12'h280, pend_m);
    $display("test 2 end");
    for (int w = 0; w < 8; w++) begin
      r = $urandom();
      bus(1'b1, 12'h400 + 12'(4 * w), r, 4'hF);
      bus(1'b1, 12'h400 + 12'(4 * w), ~r, 4'h3);
      rd(12'h400 + 12'(4 * w), r & 32'hC0C0_C0C0);
      for (int k = 0; k < 4; k++) begin
        pr_m[4 * w + k] = r[8 * k + 6 +: 2];
      end
    end
    $display("test 3 end");
    bus(1'b1, 12'h100, 32'hFFFF_FFFF, 4'hF);
    rd(12'h308, best(pend_m));
    chk({23'h0, irq_offer_valid, 1'b0, irq_offer_prio, irq_offer_num},
      best(pend_m));
    act_m = 32'h1 << b;
    take <= 1'b1;
    @(posedge mclk);
    take <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(12'h300, act_m);
    bus(1'b1, 12'h280, 32'hFFFF_FFFF, 4'hF);
    rd(12'h300, act_m);
    irq_lines <= act_m;
    @(posedge mclk);
    irq_lines <= 32'h0000_0000;
    repeat (4) @(posedge mclk);
    rd(12'h200, act_m);
    leave <= 1'b1;
    @(posedge mclk);
    leave <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(12'h300, 32'h0000_0000);
    rd(12'h200, act_m);
    $display("test 4 end");
    bus(1'b1, 12'h280, 32'hFFFF_FFFF, 4'hF);
    rd(12'h200, 32'h0000_0000);
    bus(1'b1, 12'h304, act_m, 4'hF);
    irq_lines <= act_m;
    repeat (4) @(posedge mclk);
    rd(12'h200, act_m);
    rd(12'h308, best(act_m));
    take <= 1'b1;
    @(posedge mclk);
    take <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(12'h300, act_m);
    rd(12'h200, 32'h0000_0000);
    leave <= 1'b1;
    @(posedge mclk);
    leave <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(12'h200, act_m);
    rd(12'h300, 32'h0000_0000);
    bus(1'b1, 12'h280, act_m, 4'hF);
    rd(12'h200, act_m);
    irq_lines <= 32'h0000_0000;
    repeat (4) @(posedge mclk);
    bus(1'b1, 12'h280, act_m, 4'hF);
    rd(12'h200, 32'h0000_0000);
    $display("test 5 end");
    conclude();
  end
endmodule // interrupt_pending_priority_ctrl_test
